/* hw/gpa_port.sv */
module gpa_port #(
	parameter gpa_pkg::gpa_variant_type VARIANT = gpa_pkg::GPA_VAR_FULL
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// command port
	input wire logic cmd_write,
	input wire logic cmd_read,
	input wire logic [gpa_pkg::GPA_IDX_W-1:0] cmd_index,
	input wire logic [gpa_pkg::GPA_REG_W-1:0] cmd_wdata,
	output logic cmd_ready,
	output logic cmd_rvalid,
	output logic cmd_error,
	output logic [gpa_pkg::GPA_REG_W-1:0] cmd_rdata,
	// module-level controls
	input wire logic soft_reset,
	input wire logic pwm_feature_en,
	input wire logic hw_flow_en,
	// peripherals driving pins and vref_enable
	input wire logic network_active,
	input wire logic tx_active,
	input wire logic uart_busy,
	input wire logic uart_txd,
	input wire logic uart_rts,
	input wire logic pwm_level,
	input wire logic adc_converting,
	input wire logic amp_bypass,
	// peripherals fed from pins
	output logic uart_rxd,
	output logic uart_cts,
	output logic [3:0] analog_enable,
	output logic vref_enable,
	// pins
	input wire logic [gpa_pkg::GPA_PINS-1:0] pin_in,
	output logic [gpa_pkg::GPA_PINS-1:0] pin_out,
	output logic [gpa_pkg::GPA_PINS-1:0] pin_oe_n
);
	import gpa_pkg::*;

	typedef struct packed {
		gpa_state_type st;
		logic [31:0] alt;
		logic [31:0] dir;
		logic [31:0] outv;
		logic rvalid;
		logic rerr;
		logic rd_nv;
		logic [31:0] rdata;
	} gpa_regs_type;

	// working copies hold the defaults so pins are sane before the reload
	localparam gpa_regs_type GPA_REGS_RST = '{
		st: GPA_ST_FETCH_DIR,
		alt: GPA_ALT_RST,
		dir: GPA_DIR_INIT_RST,
		outv: GPA_OUT_INIT_RST,
		rvalid: 1'b0,
		rerr: 1'b0,
		rd_nv: 1'b0,
		rdata: 32'h00000000
	};

	// bits a variant takes away; pin and alt positions coincide
	function automatic logic [31:0] gpa_variant_drop(input gpa_variant_type v);
		logic [31:0] m;
		m = 32'h00000000;
		if (v != GPA_VAR_FULL) begin
			m[GPA_BIT_TXA_HIGH] = 1'b1;
			m[GPA_BIT_VREF] = 1'b1;
		end
		if (v == GPA_VAR_AMPLIFIED) begin
			m[GPA_BIT_TXA_LOW] = 1'b1;
			m[GPA_BIT_AN0] = 1'b1;
		end
		return m;
	endfunction

	localparam logic [31:0] ALT_OK = GPA_ALT_IMPL & ~gpa_variant_drop(VARIANT);
	localparam logic [31:0] PIN_DROP = gpa_variant_drop(VARIANT);
	localparam logic AMPLIFIED = (VARIANT == GPA_VAR_AMPLIFIED);

	gpa_regs_type r_q;
	gpa_regs_type r_d;

	gpa_nv_if nvif();
	gpa_pin_if #(.N(GPA_PINS)) pif();

	gpa_nv_store u_nv (
		.clock(clock),
		.reset_n(reset_n),
		.nv(nvif.store)
	);

	gpa_pin_mux #(.N(GPA_PINS)) u_mux (
		.p(pif.mux)
	);

	logic [31:0] alt_eff;
	logic [GPA_PINS-1:0] claim;
	logic [GPA_PINS-1:0] poe;
	logic [GPA_PINS-1:0] pval;
	logic flow_cts;
	logic flow_rts;
	logic pwm_on;

	// reserved bits are stored but masked off here
	assign alt_eff = r_q.alt & ALT_OK;
	assign flow_cts = alt_eff[GPA_BIT_CTS] & hw_flow_en;
	assign flow_rts = alt_eff[GPA_BIT_RTS] & hw_flow_en;
	assign pwm_on = pwm_feature_en;

	// peripheral routing per claimed pin
	always_comb begin
		claim = '0;
		poe = '0;
		pval = '0;
		// indicator still obeys direction; output bit forces high
		claim[GPA_BIT_NET] = alt_eff[GPA_BIT_NET];
		poe[GPA_BIT_NET] = r_q.dir[GPA_BIT_NET];
		pval[GPA_BIT_NET] = network_active | r_q.outv[GPA_BIT_NET];
		claim[GPA_BIT_TXA_LOW] = alt_eff[GPA_BIT_TXA_LOW];
		poe[GPA_BIT_TXA_LOW] = 1'b1;
		pval[GPA_BIT_TXA_LOW] = ~tx_active;
		claim[GPA_BIT_TXA_HIGH] = alt_eff[GPA_BIT_TXA_HIGH];
		poe[GPA_BIT_TXA_HIGH] = 1'b1;
		pval[GPA_BIT_TXA_HIGH] = tx_active;
		// analog inputs: pin released, converter sees it
		claim[GPA_BIT_AN3] = alt_eff[GPA_BIT_AN3];
		claim[GPA_BIT_AN1] = alt_eff[GPA_BIT_AN1];
		claim[GPA_BIT_AN0] = alt_eff[GPA_BIT_AN0];
		// pwm takes the pin whatever the analog bit says
		claim[GPA_BIT_AN2] = alt_eff[GPA_BIT_AN2] | pwm_on;
		poe[GPA_BIT_AN2] = pwm_on;
		pval[GPA_BIT_AN2] = pwm_on & pwm_level;
		claim[GPA_BIT_CTS] = flow_cts;
		claim[GPA_BIT_RTS] = flow_rts;
		poe[GPA_BIT_RTS] = 1'b1;
		pval[GPA_BIT_RTS] = uart_rts;
		claim[GPA_BIT_RXD] = alt_eff[GPA_BIT_RXD];
		claim[GPA_BIT_TXD] = alt_eff[GPA_BIT_TXD];
		poe[GPA_BIT_TXD] = 1'b1;
		pval[GPA_BIT_TXD] = uart_txd;
		claim[GPA_BIT_VREF] = alt_eff[GPA_BIT_VREF];
		claim[GPA_BIT_UART_BUSY] = alt_eff[GPA_BIT_UART_BUSY];
		poe[GPA_BIT_UART_BUSY] = 1'b1;
		pval[GPA_BIT_UART_BUSY] = uart_busy;
		// amplifier bypass owns its pin outright on that variant
		if (AMPLIFIED) begin
			claim[GPA_BIT_AN0] = 1'b1;
			poe[GPA_BIT_AN0] = 1'b1;
			pval[GPA_BIT_AN0] = amp_bypass;
		end
	end

	assign pif.claim = claim;
	assign pif.poe = poe;
	assign pif.pval = pval;
	assign pif.dir = r_q.dir[GPA_PINS-1:0];
	assign pif.outv = r_q.outv[GPA_PINS-1:0];
	assign pif.free = ~PIN_DROP[GPA_PINS-1:0];
	assign pin_out = pif.drive;
	assign pin_oe_n = pif.oe_n;

	// inputs handed back to peripherals; idle levels when unclaimed
	assign uart_rxd = alt_eff[GPA_BIT_RXD] ? pin_in[GPA_BIT_RXD] : 1'b1;
	assign uart_cts = flow_cts ? pin_in[GPA_BIT_CTS] : 1'b0;
	assign analog_enable[3] = alt_eff[GPA_BIT_AN3];
	assign analog_enable[2] = alt_eff[GPA_BIT_AN2] & ~pwm_on;
	assign analog_enable[1] = alt_eff[GPA_BIT_AN1];
	assign analog_enable[0] = alt_eff[GPA_BIT_AN0] & ~AMPLIFIED;
	assign vref_enable = alt_eff[GPA_BIT_VREF] & adc_converting;

	// commands wait while the initial values are being fetched
	assign cmd_ready = (r_q.st == GPA_ST_RUN) && !soft_reset;

	// next state: reload sequence and command decode
	always_comb begin
		r_d = r_q;
		r_d.rvalid = 1'b0;
		r_d.rerr = 1'b0;
		nvif.rd = 1'b0;
		nvif.raddr = GPA_NV_DIR;
		nvif.wr = 1'b0;
		nvif.waddr = GPA_NV_DIR;
		nvif.wdata = cmd_wdata;
		unique case (r_q.st)
			GPA_ST_FETCH_DIR: begin
				nvif.rd = 1'b1;
				nvif.raddr = GPA_NV_DIR;
				r_d.st = GPA_ST_FETCH_OUT;
			end
			GPA_ST_FETCH_OUT: begin
				r_d.dir = nvif.rdata;
				nvif.rd = 1'b1;
				nvif.raddr = GPA_NV_OUT;
				r_d.st = GPA_ST_LOAD_OUT;
			end
			GPA_ST_LOAD_OUT: begin
				r_d.outv = nvif.rdata;
				r_d.st = GPA_ST_RUN;
			end
			GPA_ST_RUN: begin
				if (soft_reset) begin
					// soft reset wins over a command in the same cycle
					r_d.st = GPA_ST_FETCH_DIR;
				end else if (cmd_write) begin
					unique case (cmd_index)
						GPA_IDX_ALT: r_d.alt = cmd_wdata;
						GPA_IDX_DIR: r_d.dir = cmd_wdata;
						GPA_IDX_OUT: r_d.outv = cmd_wdata;
						GPA_IDX_DIR_INIT: begin
							nvif.wr = 1'b1;
							nvif.waddr = GPA_NV_DIR;
						end
						GPA_IDX_OUT_INIT: begin
							nvif.wr = 1'b1;
							nvif.waddr = GPA_NV_OUT;
						end
						default: r_d.rerr = 1'b1;
					endcase
				end else if (cmd_read) begin
					r_d.rvalid = 1'b1;
					r_d.rd_nv = 1'b0;
					r_d.rdata = 32'h00000000;
					unique case (cmd_index)
						GPA_IDX_ALT: r_d.rdata = r_q.alt;
						GPA_IDX_DIR: r_d.rdata = r_q.dir;
						GPA_IDX_OUT: r_d.rdata = r_q.outv;
						GPA_IDX_SNAP: r_d.rdata = {8'h00, pin_in};
						GPA_IDX_DIR_INIT: begin
							nvif.rd = 1'b1;
							nvif.raddr = GPA_NV_DIR;
							r_d.rd_nv = 1'b1;
						end
						GPA_IDX_OUT_INIT: begin
							nvif.rd = 1'b1;
							nvif.raddr = GPA_NV_OUT;
							r_d.rd_nv = 1'b1;
						end
						default: r_d.rerr = 1'b1;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			r_q <= GPA_REGS_RST;
		end else begin
			r_q <= r_d;
		end
	end

	// both read sources are flops; the select is registered too
	assign cmd_rdata = r_q.rd_nv ? nvif.rdata : r_q.rdata;
	assign cmd_rvalid = r_q.rvalid;
	assign cmd_error = r_q.rerr;
endmodule

/* hw/gpa_pkg.sv */
package gpa_pkg;
	localparam int GPA_PINS = 24;
	localparam int GPA_REG_W = 32;
	localparam int GPA_IDX_W = 8;
	// register indices on the command port
	localparam logic [7:0] GPA_IDX_ALT = 8'h15;
	localparam logic [7:0] GPA_IDX_DIR = 8'h16;
	localparam logic [7:0] GPA_IDX_DIR_INIT = 8'h17;
	localparam logic [7:0] GPA_IDX_OUT = 8'h18;
	localparam logic [7:0] GPA_IDX_OUT_INIT = 8'h19;
	localparam logic [7:0] GPA_IDX_SNAP = 8'h1A;
	// reset values
	localparam logic [31:0] GPA_ALT_RST = 32'h00000600;
	localparam logic [31:0] GPA_DIR_INIT_RST = 32'h000142CC;
	localparam logic [31:0] GPA_OUT_INIT_RST = 32'h00000000;
	// alternate-function bits that have a peripheral behind them
	localparam logic [31:0] GPA_ALT_IMPL = 32'h00E2FF80;
	// initial-value store slots
	localparam logic GPA_NV_DIR = 1'b0;
	localparam logic GPA_NV_OUT = 1'b1;
	// alternate-function bit positions, equal to pin numbers
	localparam int GPA_BIT_NET = 23;
	localparam int GPA_BIT_TXA_LOW = 22;
	localparam int GPA_BIT_TXA_HIGH = 21;
	localparam int GPA_BIT_AN3 = 17;
	localparam int GPA_BIT_AN2 = 15;
	localparam int GPA_BIT_AN1 = 14;
	localparam int GPA_BIT_AN0 = 13;
	localparam int GPA_BIT_CTS = 12;
	localparam int GPA_BIT_RTS = 11;
	localparam int GPA_BIT_RXD = 10;
	localparam int GPA_BIT_TXD = 9;
	localparam int GPA_BIT_VREF = 8;
	localparam int GPA_BIT_UART_BUSY = 7;
	typedef enum logic [1:0] {
		GPA_VAR_FULL,
		GPA_VAR_LONG_RANGE,
		GPA_VAR_AMPLIFIED
	} gpa_variant_type;
	typedef enum logic [1:0] {
		GPA_ST_FETCH_DIR,
		GPA_ST_FETCH_OUT,
		GPA_ST_LOAD_OUT,
		GPA_ST_RUN
	} gpa_state_type;
endpackage

/* hw/gpa_if.sv */
interface gpa_nv_if;
	logic rd;
	logic raddr;
	logic wr;
	logic waddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	modport ctrl(output rd, raddr, wr, waddr, wdata, input rdata);
	modport store(input rd, raddr, wr, waddr, wdata, output rdata);
endinterface

interface gpa_pin_if #(parameter int N = 24);
	logic [N-1:0] claim;
	logic [N-1:0] poe;
	logic [N-1:0] pval;
	logic [N-1:0] dir;
	logic [N-1:0] outv;
	logic [N-1:0] free;
	logic [N-1:0] drive;
	logic [N-1:0] oe_n;
	modport ctrl(output claim, poe, pval, dir, outv, free, input drive, oe_n);
	modport mux(input claim, poe, pval, dir, outv, free, output drive, oe_n);
endinterface

/* hw/gpa_nv_store.sv */
module gpa_nv_store (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// access port
	gpa_nv_if.store nv
);
	import gpa_pkg::*;

	typedef struct packed {
		logic [31:0] dir_init;
		logic [31:0] out_init;
		logic [31:0] rdata;
	} gpa_nv_type;

	// power-up contents stand in for the factory defaults
	localparam gpa_nv_type GPA_NV_RST = '{
		dir_init: GPA_DIR_INIT_RST,
		out_init: GPA_OUT_INIT_RST,
		rdata: 32'h00000000
	};

	gpa_nv_type r_q;
	gpa_nv_type r_d;

	always_comb begin
		r_d = r_q;
		if (nv.rd) begin
			r_d.rdata = (nv.raddr == GPA_NV_OUT) ? r_q.out_init : r_q.dir_init;
		end
		if (nv.wr && nv.waddr == GPA_NV_OUT) begin
			r_d.out_init = nv.wdata;
		end
		if (nv.wr && nv.waddr == GPA_NV_DIR) begin
			r_d.dir_init = nv.wdata;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			r_q <= GPA_NV_RST;
		end else begin
			r_q <= r_d;
		end
	end

	assign nv.rdata = r_q.rdata;
endmodule

/* hw/gpa_pin_mux.sv */
module gpa_pin_mux #(
	parameter int N = 24
) (
	// pin control
	gpa_pin_if.mux p
);
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_pin
			logic oe;
			logic val;
			always_comb begin
				// a claimed pin ignores direction and output here; poe and pval decide it
				if (p.claim[i]) begin
					oe = p.poe[i];
					val = p.pval[i];
				end else if (p.free[i]) begin
					oe = p.dir[i];
					val = p.dir[i] & p.outv[i];
				end else begin
					oe = 1'b0;
					val = 1'b0;
				end
			end
			assign p.drive[i] = val;
			assign p.oe_n[i] = ~oe;
		end
	endgenerate
endmodule

/* test/gpa_port_chk.sv */
module gpa_port_chk (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// command port
	input wire logic cmd_write,
	input wire logic cmd_read,
	input wire logic [7:0] cmd_index,
	input wire logic [31:0] cmd_wdata,
	input wire logic cmd_ready,
	input wire logic cmd_rvalid,
	input wire logic cmd_error,
	input wire logic [31:0] cmd_rdata,
	// controls and peripherals
	input wire logic soft_reset,
	input wire logic pwm_feature_en,
	input wire logic hw_flow_en,
	input wire logic pwm_level,
	input wire logic uart_cts,
	input wire logic [3:0] analog_enable,
	// pins
	input wire logic [23:0] pin_in,
	input wire logic [23:0] pin_out,
	input wire logic [23:0] pin_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	import gpa_pkg::*;
	logic take_wr;
	logic take_rd;
	assign take_wr = cmd_ready && cmd_write;
	assign take_rd = cmd_ready && cmd_read && !cmd_write;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// every read is answered; unmapped indices answer with the error flag as well
	property p_answer; take_rd |=>
		cmd_rvalid && (cmd_error == !($past(cmd_index) inside {[GPA_IDX_ALT:GPA_IDX_SNAP]}));
	endproperty
	a_answer: assert property (p_answer) else $error("read answer missing");
	property p_dir; take_wr && cmd_index == GPA_IDX_DIR |=> pin_oe_n[6:0] == ~$past(cmd_wdata[6:0]);
	endproperty
	a_dir: assert property (p_dir) else $error("direction not on pins");
	property p_out; take_wr && cmd_index == GPA_IDX_OUT |=>
		pin_out[6:0] == ($past(cmd_wdata[6:0]) & ~pin_oe_n[6:0]); endproperty
	a_out: assert property (p_out) else $error("output not on pins");
	property p_snap; take_rd && cmd_index == GPA_IDX_SNAP |=> cmd_rdata == {8'h00, $past(pin_in)};
	endproperty
	a_snap: assert property (p_snap) else $error("snapshot wrong");
	property p_snap_ro; take_wr && cmd_index == GPA_IDX_SNAP |=> cmd_error; endproperty
	a_snap_ro: assert property (p_snap_ro) else $error("snapshot written");
	// ready already folds in soft_reset, so the running state is seen one cycle back
	property p_reload; soft_reset && $past(cmd_ready) |=>
		!cmd_ready [*3] ##1 (cmd_ready || soft_reset);
	endproperty
	a_reload: assert property (p_reload) else $error("reload timing");
	property p_cts; uart_cts |-> hw_flow_en && pin_in[12]; endproperty
	a_cts: assert property (p_cts) else $error("cts without flow control");
	property p_pwm; pwm_feature_en |-> !pin_oe_n[15] && pin_out[15] == pwm_level && !analog_enable[2];
	endproperty
	a_pwm: assert property (p_pwm) else $error("pwm pin wrong");
endmodule

bind gpa_port gpa_port_chk chk_u (.clock, .reset_n, .cmd_write, .cmd_read, .cmd_index,
	.cmd_wdata, .cmd_ready, .cmd_rvalid, .cmd_error, .cmd_rdata, .soft_reset, .pwm_feature_en,
	.hw_flow_en, .pwm_level, .uart_cts, .analog_enable, .pin_in, .pin_out, .pin_oe_n);

/* test/gpa_ext_pins.sv */
module gpa_ext_pins (
	// pins from the port
	input wire logic [23:0] pin_out,
	input wire logic [23:0] pin_oe_n,
	// level the outside circuit puts on released pins
	input wire logic [23:0] ext_val,
	// level seen back at the port
	output logic [23:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// a driving port wins; no pulls, so released pins show the outside level
	assign pin_in = (pin_out & ~pin_oe_n) | (ext_val & pin_oe_n);
endmodule

/* test/gpa_port_tb.sv */
module gpa_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gpa_pkg::*;
	logic clock = 0, reset_n = 0, cmd_write = 0, cmd_read = 0, soft_reset = 0;
	logic pwm_feature_en = 0, hw_flow_en = 0, network_active = 0, tx_active = 0, uart_busy = 0;
	logic uart_txd = 1, uart_rts = 1, pwm_level = 1, adc_converting = 0, amp_bypass = 0;
	logic [7:0] cmd_index = 8'h00;
	logic [31:0] cmd_wdata = 32'h00000000;
	logic [23:0] ext_val = 24'h001000;
	logic cmd_ready, cmd_rvalid, cmd_error, uart_rxd, uart_cts, vref_enable;
	logic [31:0] cmd_rdata;
	logic [3:0] analog_enable;
	logic [23:0] pin_in, pin_out, pin_oe_n;
	logic amp_vref;
	logic [23:0] amp_pin_out, amp_pin_oe_n;
	int miscompares = 0, tests_run = 0;

	gpa_port dut_u (.*);
	gpa_ext_pins ext_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val), .pin_in(pin_in));
	// amplified variant shares every request, only its pins and vref_enable are compared
	gpa_port #(.VARIANT(GPA_VAR_AMPLIFIED)) dut_amp_u (
		.clock(clock), .reset_n(reset_n), .cmd_write(cmd_write), .cmd_read(cmd_read),
		.cmd_index(cmd_index), .cmd_wdata(cmd_wdata), .cmd_ready(), .cmd_rvalid(),
		.cmd_error(), .cmd_rdata(), .soft_reset(soft_reset), .pwm_feature_en(pwm_feature_en),
		.hw_flow_en(hw_flow_en), .network_active(network_active), .tx_active(tx_active),
		.uart_busy(uart_busy), .uart_txd(uart_txd), .uart_rts(uart_rts),
		.pwm_level(pwm_level), .adc_converting(adc_converting), .amp_bypass(amp_bypass),
		.uart_rxd(), .uart_cts(), .analog_enable(), .vref_enable(amp_vref),
		.pin_in(ext_val), .pin_out(amp_pin_out), .pin_oe_n(amp_pin_oe_n));

	always #10 clock = ~clock;

	task close_out;
		if (miscompares == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// requests are held until a rising edge sees cmd_ready
	task wr(input logic [7:0] idx, input logic [31:0] d);
		@(negedge clock);
		cmd_index = idx;
		cmd_wdata = d;
		cmd_write = 1;
		while (cmd_ready !== 1'b1) @(negedge clock);
		@(negedge clock);
		cmd_write = 0;
	endtask

	task rd(input logic [7:0] idx, input logic [31:0] exp);
		logic ok;
		ok = idx >= GPA_IDX_ALT && idx <= GPA_IDX_SNAP;
		@(negedge clock);
		cmd_index = idx;
		cmd_read = 1;
		while (cmd_ready !== 1'b1) @(negedge clock);
		@(negedge clock);
		cmd_read = 0;
		chk("answer", {30'h0, !ok, 1'b1}, {30'h0, cmd_error, cmd_rvalid});
		if (ok)
			chk("rdata", exp, cmd_rdata);
	endtask

	initial begin
		repeat (5) @(negedge clock);
		reset_n = 1;
		rd(GPA_IDX_ALT, 32'h00000600);
		rd(GPA_IDX_DIR, 32'h000142CC);
		rd(GPA_IDX_DIR_INIT, 32'h000142CC);
		rd(GPA_IDX_OUT, 32'h00000000);
		rd(GPA_IDX_OUT_INIT, 32'h00000000);
		chk("pins_a", 32'h3300, {16'h0, pin_oe_n[7:0], pin_out[7:0]});
		chk("txd", 32'h1, {29'h0, uart_rxd, pin_oe_n[9], pin_out[9]});
		wr(GPA_IDX_DIR, 32'hAB00007F);
		wr(GPA_IDX_OUT, 32'hCD000055);
		chk("pins_a", 32'h8055, {16'h0, pin_oe_n[7:0], pin_out[7:0]});
		chk("txd", 32'h1, {30'h0, pin_oe_n[9], pin_out[9]});
		rd(GPA_IDX_DIR, 32'hAB00007F);
		wr(GPA_IDX_ALT, 32'hFF1D007F);
		chk("pins_a", 32'h8055, {16'h0, pin_oe_n[7:0], pin_out[7:0]});
		chk("txd_off", 32'h2, {30'h0, pin_oe_n[9], pin_out[9]});
		rd(GPA_IDX_ALT, 32'hFF1D007F);
		network_active = 1;
		tx_active = 1;
		hw_flow_en = 1;
		adc_converting = 1;
		amp_bypass = 1;
		uart_busy = 1;
		wr(GPA_IDX_DIR, 32'h00800000);
		wr(GPA_IDX_OUT, 32'h00000000);
		wr(GPA_IDX_ALT, 32'h00E2FF80);
		chk("net_tx", 32'h5, {26'h0, pin_oe_n[23:21], pin_out[23:21]});
		chk("busy", 32'h1, {30'h0, pin_oe_n[7], pin_out[7]});
		chk("amp_net", 32'h1C, {26'h0, amp_pin_oe_n[23:21], amp_pin_out[23:21]});
		chk("amp_pins", 32'h6, {28'h0, amp_pin_oe_n[13], amp_pin_out[13], amp_pin_oe_n[8], amp_vref});
		chk("analog", 32'hF, {28'h0, analog_enable});
		chk("adc_pins", 32'hF, {28'h0, pin_oe_n[17], pin_oe_n[15:13]});
		chk("flow", 32'h5, {29'h0, uart_cts, pin_oe_n[11], pin_out[11]});
		chk("vref", 32'h3, {30'h0, vref_enable, pin_oe_n[8]});
		network_active = 0;
		tx_active = 0;
		wr(GPA_IDX_OUT, 32'h00800000);
		chk("net_tx", 32'h6, {26'h0, pin_oe_n[23:21], pin_out[23:21]});
		wr(GPA_IDX_OUT, 32'h00000000);
		chk("net", 32'h0, {30'h0, pin_oe_n[23], pin_out[23]});
		wr(GPA_IDX_DIR, 32'h00000000);
		chk("net", 32'h2, {30'h0, pin_oe_n[23], pin_out[23]});
		pwm_feature_en = 1;
		@(negedge clock);
		chk("pwm", 32'h1, {29'h0, analog_enable[2], pin_oe_n[15], pin_out[15]});
		wr(GPA_IDX_ALT, 32'h00000000);
		ext_val = 24'h5A3C96;
		rd(GPA_IDX_SNAP, 32'h005ABC96);
		wr(GPA_IDX_SNAP, 32'h00000001);
		chk("wr_error", 32'h1, {31'h0, cmd_error});
		rd(8'h20, 32'h00000000);
		wr(GPA_IDX_DIR_INIT, 32'h0000000F);
		wr(GPA_IDX_OUT_INIT, 32'h00000005);
		chk("pins_a", 32'hFF00, {16'h0, pin_oe_n[7:0], pin_out[7:0]});
		soft_reset = 1;
		@(negedge clock);
		soft_reset = 0;
		rd(GPA_IDX_DIR, 32'h0000000F);
		rd(GPA_IDX_OUT, 32'h00000005);
		chk("pins_a", 32'hF005, {16'h0, pin_oe_n[7:0], pin_out[7:0]});
		close_out;
	end

	// whole sequence is well under a hundred cycles, far inside the 1000-cycle limit
	initial begin
		#20000;
		miscompares++;
		close_out;
	end
endmodule
